// >>> rtl/pcsel_counter.sv
// third performance counter with event selection and avalon registers
`timescale 1ns/1ps
module pcsel_counter #(
	parameter int THR_MULT_W = 2
) (
	// clock and reset
	input  wire logic                       clk,
	input  wire logic                       rst_b,
	// avalon-mm slave
	input  wire logic [3:0]                 avs_address,
	input  wire logic                       avs_read,
	input  wire logic                       avs_write,
	input  wire logic [31:0]                avs_writedata,
	input  wire logic [3:0]                 avs_byteenable,
	output logic [31:0]                     avs_readdata,
	output logic                            avs_waitrequest,
	// core event sources
	input  wire logic [pcsel_pkg::PCSEL_TB_W-1:0] timebase_lower,
	input  wire logic                       monitor_in,
	input  wire logic [1:0]                 completed_count,
	input  wire logic [1:0]                 dispatched_count,
	input  wire logic [1:0]                 vr_dispatch_count,
	input  wire logic [1:0]                 vr_stall_count,
	input  wire logic [5:0]                 int_rename_valid,
	input  wire logic [3:0]                 fp_queue_valid,
	input  wire logic                       fpu_complete,
	input  wire logic                       stwcx_complete,
	input  wire logic [1:0]                 load_piece_count,
	input  wire logic                       zero_len_load_string,
	input  wire logic                       single_step_trace,
	input  wire logic                       itable_search_active,
	input  wire logic                       data_translation_buffer_miss,
	input  wire logic                       icache_miss_cancel,
	input  wire logic                       dcache_op_hit,
	input  wire logic                       lmq_oldest_wait,
	input  wire logic                       snoop_push,
	input  wire logic                       dcache_miss,
	input  wire logic                       stream2_fetch,
	input  wire logic [1:0]                 taken_branch_count,
	input  wire logic                       branch_flush,
	input  wire logic                       buf2_correct,
	input  wire logic                       buf3_active,
	input  wire logic                       ctr_stall,
	input  wire logic                       fast_branch_target_cache_hit,
	input  wire logic                       link_stack_miss,
	input  wire logic                       other_counter_negative,
	input  wire logic                       other_counter_condition_enable,
	// counter state
	output logic [pcsel_pkg::PCSEL_CNT_W-1:0] third_event_counter
);
	import pcsel_pkg::*;

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	logic [31:0]             ctrl_reg;
	logic [31:0]             thr_reg;
	logic [PCSEL_CNT_W-1:0]  cnt_reg;
	logic [PCSEL_CNT_W-1:0]  cnt_next;
	logic [2:0]              inc_next;
	logic [2:0]              inc_reg;
	pcsel_bus_t              bus_reg;
	logic                    tb_bit;
	logic                    tb_prev_reg;
	logic                    mon_prev_reg;
	logic                    exc_prev_reg;
	logic                    exc_now;
	logic                    search_over;
	logic [7:0]              search_cnt_reg;
	logic [15:0]             search_thr;
	logic                    search_flag_reg;
	logic [4:0]              sel;
	logic [1:0]              tbs;
	logic [THR_MULT_W-1:0]   mult;
	logic                    wr_hit;

	assign sel  = ctrl_reg[PCSEL_CTRL_SEL_LSB +: PCSEL_SEL_W];
	assign tbs  = ctrl_reg[PCSEL_CTRL_TBS_LSB +: 2];
	assign mult = ctrl_reg[PCSEL_CTRL_MUL_LSB +: THR_MULT_W];

	// ----------------------------------------------------------------
	// edge sources
	// ----------------------------------------------------------------
	always_comb begin
		case (tbs) // R5
			2'b00:   tb_bit = timebase_lower[31];
			2'b01:   tb_bit = timebase_lower[23];
			2'b10:   tb_bit = timebase_lower[19];
			default: tb_bit = timebase_lower[15];
		endcase
	end

	// the global exception enable plays no part here
	assign exc_now = other_counter_negative &
		(other_counter_condition_enable | ctrl_reg[PCSEL_CTRL_CE_BIT]) |
		(cnt_reg[PCSEL_CNT_W-1] & ctrl_reg[PCSEL_CTRL_CE_BIT]); // R7

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			tb_prev_reg  <= 1'b0;
			mon_prev_reg <= 1'b0;
			exc_prev_reg <= 1'b0;
		end else begin
			tb_prev_reg  <= tb_bit; // R24
			mon_prev_reg <= monitor_in; // R24
			exc_prev_reg <= exc_now;
		end
	end

	// ----------------------------------------------------------------
	// table search length against scaled threshold
	// ----------------------------------------------------------------
	assign search_thr = 16'(thr_reg[7:0]) << (2 * mult); // R17
	assign search_over = itable_search_active &&
		(16'(search_cnt_reg) == search_thr) && !search_flag_reg;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			search_cnt_reg  <= 8'h00;
			search_flag_reg <= 1'b0;
		end else if (!itable_search_active) begin
			search_cnt_reg  <= 8'h00;
			search_flag_reg <= 1'b0;
		end else begin
			if (search_cnt_reg != 8'hff)
				search_cnt_reg <= search_cnt_reg + 8'h01;
			if (search_over)
				search_flag_reg <= 1'b1; // R17
		end
	end

	// ----------------------------------------------------------------
	// event select
	// ----------------------------------------------------------------
	always_comb begin
		inc_next = 3'h0;
		case (sel) // R23
			5'h00: inc_next = 3'h0; // R1
			5'h01: inc_next = 3'h1; // R2
			5'h02: inc_next = {1'b0, completed_count}; // R3
			5'h03: inc_next = {2'b00, tb_bit & ~tb_prev_reg}; // R5
			5'h04: inc_next = {1'b0, dispatched_count}; // R6
			5'h05: inc_next = {2'b00, exc_now & ~exc_prev_reg}; // R7
			5'h06: inc_next = 3'h0; // R8
			5'h07: inc_next = {2'b00, monitor_in & ~mon_prev_reg}; // R9
			5'h08: inc_next = {2'b00, completed_count == 2'd2}; // R10
			5'h09: inc_next = {2'b00, dispatched_count == 2'd1}; // R10
			5'h0a: inc_next = {1'b0, vr_dispatch_count}; // R11
			5'h0b: inc_next = (vr_stall_count > 2'd2) ? 3'h2 :
				{1'b0, vr_stall_count}; // R12
			5'h0c: inc_next = {2'b00,
				32'(int_rename_valid) >= thr_reg}; // R13
			5'h0d: inc_next = (fp_queue_valid > 4'd7) ? 3'h7 :
				fp_queue_valid[2:0]; // R14
			5'h0e: inc_next = {2'b00, fpu_complete}; // R15
			5'h0f: inc_next = {2'b00, stwcx_complete}; // R15
			5'h10: inc_next = {1'b0, load_piece_count} +
				{2'b00, zero_len_load_string & single_step_trace}; // R16
			5'h11: inc_next = {2'b00, search_over}; // R17
			5'h12: inc_next = {2'b00, data_translation_buffer_miss}; // R18
			5'h13: inc_next = {2'b00, icache_miss_cancel}; // R18
			5'h14: inc_next = {2'b00, dcache_op_hit}; // R18
			5'h15: inc_next = {2'b00, lmq_oldest_wait}; // R19
			5'h16: inc_next = {2'b00, snoop_push}; // R20
			5'h17: inc_next = {2'b00, dcache_miss}; // R20
			5'h18: inc_next = {2'b00, stream2_fetch}; // R20
			5'h19: inc_next = {1'b0, taken_branch_count}; // R21
			5'h1a: inc_next = {2'b00, branch_flush}; // R21
			5'h1b: inc_next = {2'b00, buf2_correct}; // R22
			5'h1c: inc_next = {2'b00, buf3_active}; // R22
			5'h1d: inc_next = {2'b00, ctr_stall}; // R22
			5'h1e: inc_next = {2'b00, fast_branch_target_cache_hit}; // R22
			5'h1f: inc_next = {2'b00, link_stack_miss}; // R22
			default: inc_next = 3'h0;
		endcase
	end

	assign inc_reg = inc_next;
	assign cnt_next = cnt_reg + PCSEL_CNT_W'(inc_reg);

	// ----------------------------------------------------------------
	// avalon slave: one wait cycle, answer on second cycle
	// ----------------------------------------------------------------
	assign wr_hit = avs_write && bus_reg == PCSEL_BUS_ACK;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			bus_reg         <= PCSEL_BUS_IDLE;
			avs_waitrequest <= 1'b1;
			avs_readdata    <= 32'h0000_0000;
		end else if (bus_reg == PCSEL_BUS_IDLE && (avs_read || avs_write)) begin
			bus_reg         <= PCSEL_BUS_ACK;
			avs_waitrequest <= 1'b0;
			case (avs_address)
				PCSEL_OFS_CTRL:  avs_readdata <= ctrl_reg;
				PCSEL_OFS_COUNT: avs_readdata <= cnt_reg;
				PCSEL_OFS_THR:   avs_readdata <= thr_reg;
				PCSEL_OFS_EVENT: avs_readdata <= {29'h0, inc_next};
				default:         avs_readdata <= PCSEL_UNMAPPED;
			endcase
		end else begin
			bus_reg         <= PCSEL_BUS_IDLE;
			avs_waitrequest <= 1'b1;
		end
	end

	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] d, input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
			if (be[i]) r[i*8 +: 8] = d[i*8 +: 8];
		return r;
	endfunction

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ctrl_reg <= PCSEL_CTRL_RESET;
			thr_reg  <= PCSEL_THR_RESET;
		end else if (wr_hit) begin
			if (avs_address == PCSEL_OFS_CTRL)
				ctrl_reg <= merge(ctrl_reg, avs_writedata, avs_byteenable);
			if (avs_address == PCSEL_OFS_THR)
				thr_reg <= merge(thr_reg, avs_writedata, avs_byteenable);
		end
	end

	// software write to the count wins over that cycle's event
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			cnt_reg <= PCSEL_CNT_RESET;
		else if (wr_hit && avs_address == PCSEL_OFS_COUNT)
			cnt_reg <= merge(cnt_reg, avs_writedata, avs_byteenable);
		else
			cnt_reg <= cnt_next; // R23
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			third_event_counter <= PCSEL_CNT_RESET;
		else if (wr_hit && avs_address == PCSEL_OFS_COUNT)
			third_event_counter <= merge(cnt_reg, avs_writedata,
				avs_byteenable);
		else
			third_event_counter <= cnt_next;
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	sequence s_no_write;
		!(wr_hit && avs_address == PCSEL_OFS_COUNT);
	endsequence

	a_hold_when_off: assert property ((sel == 5'h00) and s_no_write
		|=> cnt_reg == $past(cnt_reg)) else $error("count moved"); // R1
	a_cycle_count: assert property ((sel == 5'h01) and s_no_write
		|=> cnt_reg == $past(cnt_reg) + 1) else $error("no tick"); // R2
	a_reserved_zero: assert property ((sel == 5'h06) and s_no_write
		|=> cnt_reg == $past(cnt_reg)) else $error("reserved"); // R8
	a_complete_add: assert property ((sel == 5'h02) and s_no_write
		|=> cnt_reg == $past(cnt_reg) + $past(completed_count))
		else $error("completion add"); // R3
	a_mon_edge: assert property ((sel == 5'h07) and s_no_write and
		(monitor_in && !mon_prev_reg)
		|=> cnt_reg == $past(cnt_reg) + 1) else $error("edge lost"); // R9
	a_mon_level: assert property ((sel == 5'h07) and s_no_write and
		(monitor_in && mon_prev_reg)
		|=> cnt_reg == $past(cnt_reg)) else $error("level counted"); // R24
	a_vr_stall_max: assert property ((sel == 5'h0b) |-> inc_next <= 3'h2)
		else $error("stall add too big"); // R12
	a_bus_answer: assert property ((avs_read || avs_write) &&
		avs_waitrequest |-> ##[1:2] !avs_waitrequest)
		else $error("no answer"); // R23
	a_out_mirror: assert property (third_event_counter == cnt_reg)
		else $error("output mismatch"); // R23

	// ----------------------------------------------------------------
	// edge events and the running sum
	// ----------------------------------------------------------------
	sequence s_tb_rise;
		tb_bit && !tb_prev_reg;
	endsequence

	sequence s_exc_rise;
		exc_now && !exc_prev_reg;
	endsequence

	// a held level must count once, not every cycle it stays high
	a_tb_edge: assert property ((sel == 5'h03) and s_no_write and s_tb_rise
		|=> cnt_reg == $past(cnt_reg) + 1)
		else $error("timebase edge lost"); // R5
	a_tb_level: assert property ((sel == 5'h03) and s_no_write and
		!(tb_bit && !tb_prev_reg) |=> cnt_reg == $past(cnt_reg))
		else $error("timebase level counted"); // R24
	a_exc_edge: assert property ((sel == 5'h05) and s_no_write and
		s_exc_rise |=> cnt_reg == $past(cnt_reg) + 1)
		else $error("exception start lost"); // R7
	a_exc_level: assert property ((sel == 5'h05) and s_no_write and
		!(exc_now && !exc_prev_reg) |=> cnt_reg == $past(cnt_reg))
		else $error("exception level counted"); // R7
	a_dispatch_add: assert property ((sel == 5'h04) and s_no_write
		|=> cnt_reg == $past(cnt_reg) + $past(dispatched_count))
		else $error("dispatch add"); // R6

	// every cycle without a count write adds exactly the selected amount
	a_count_adds: assert property (s_no_write
		|=> cnt_reg == $past(cnt_reg) + 32'($past(inc_next)))
		else $error("count add"); // R23
	a_count_write: assert property (wr_hit &&
		avs_address == PCSEL_OFS_COUNT && avs_byteenable == 4'hf
		|=> cnt_reg == $past(avs_writedata))
		else $error("count write"); // R23
	a_wait_short: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("answer stood too long"); // R23

	// ----------------------------------------------------------------
	// per-code selection
	// ----------------------------------------------------------------
	a_two_complete: assert property ((sel == 5'h08) and
		(completed_count == 2'd2) |-> inc_next == 3'h1)
		else $error("two completed"); // R10
	a_not_two: assert property ((sel == 5'h08) and
		(completed_count != 2'd2) |-> inc_next == 3'h0)
		else $error("not two completed"); // R10
	a_one_dispatch: assert property ((sel == 5'h09) and
		(dispatched_count == 2'd1) |-> inc_next == 3'h1)
		else $error("one dispatched"); // R10
	a_vr_dispatch: assert property ((sel == 5'h0a)
		|-> inc_next == {1'b0, vr_dispatch_count})
		else $error("vector dispatch"); // R11
	a_rename_over: assert property ((sel == 5'h0c) and
		(32'(int_rename_valid) >= thr_reg) |-> inc_next == 3'h1)
		else $error("rename at threshold"); // R13
	a_rename_under: assert property ((sel == 5'h0c) and
		(32'(int_rename_valid) < thr_reg) |-> inc_next == 3'h0)
		else $error("rename below threshold"); // R13
	a_fp_occupancy: assert property ((sel == 5'h0d) and
		(fp_queue_valid <= 4'd7) |-> inc_next == fp_queue_valid[2:0])
		else $error("float queue occupancy"); // R14
	a_fpu_count: assert property ((sel == 5'h0e)
		|-> inc_next == {2'b00, fpu_complete})
		else $error("float complete"); // R15
	a_stwcx_count: assert property ((sel == 5'h0f)
		|-> inc_next == {2'b00, stwcx_complete})
		else $error("conditional store"); // R15
	// a zero-length string load counts only under single-step tracing
	a_load_untraced: assert property ((sel == 5'h10) and
		!single_step_trace |-> inc_next == {1'b0, load_piece_count})
		else $error("untraced zero length"); // R16
	a_load_traced: assert property ((sel == 5'h10) and
		(single_step_trace && zero_len_load_string)
		|-> inc_next == {1'b0, load_piece_count} + 3'h1)
		else $error("traced zero length"); // R16
	a_search_once: assert property (search_flag_reg |-> !search_over)
		else $error("search counted twice"); // R17
	a_search_idle: assert property (!itable_search_active |-> !search_over)
		else $error("search without activity"); // R17
	a_data_translation_buffer_count: assert property ((sel == 5'h12)
		|-> inc_next == {2'b00, data_translation_buffer_miss})
		else $error("translation miss"); // R18
	a_lmq_wait: assert property ((sel == 5'h15)
		|-> inc_next == {2'b00, lmq_oldest_wait})
		else $error("load miss wait"); // R19
	a_dmiss_count: assert property ((sel == 5'h17)
		|-> inc_next == {2'b00, dcache_miss})
		else $error("data miss"); // R20
	a_taken_add: assert property ((sel == 5'h19)
		|-> inc_next == {1'b0, taken_branch_count})
		else $error("taken branches"); // R21
	a_link_miss: assert property ((sel == 5'h1f)
		|-> inc_next == {2'b00, link_stack_miss})
		else $error("link stack miss"); // R22
	a_flush_count: assert property ((sel == 5'h1a)
		|-> inc_next == {2'b00, branch_flush})
		else $error("branch flush"); // R21
endmodule // pcsel_counter

// >>> rtl/pcsel_pkg.sv
// constants and types for the third event counter select logic
//
// How it works
// R1 - select zero holds the counter value
// R2 - select one counts every clock cycle
// R3 - select two adds completed instructions, 0-3
// R4 - software clears branch merge for full count
// R5 - select three counts chosen timebase bit rises
// R6 - select four adds dispatched instructions, 0-3
// R7 - select five counts exception condition starts
// R8 - select six is reserved, adds zero
// R9 - select seven counts monitor input rises
// R10 - codes eight/nine: two complete, one dispatched
// R11 - code ten counts vector queue dispatches
// R12 - code eleven adds vector stalls, 0-2
// R13 - code twelve: rename buffers at threshold
// R14 - code thirteen adds float queue occupancy
// R15 - codes 14/15: float and conditional stores
// R16 - code 16: load pieces, zero-length on trace
// R17 - code 17: long table searches, scaled threshold
// R18 - codes 18-20: translation, cancelled, cache ops
// R19 - code 21: oldest load miss wait cycles
// R20 - codes 22-24: pushes, misses, stream fetches
// R21 - codes 25/26: taken branches, branch flushes
// R22 - codes 27-31: branch prediction events
// R23 - five-bit select, synchronous per-cycle add
// R24 - edges found against previous registered value
package pcsel_pkg;
	localparam int PCSEL_SEL_W = 5;
	localparam int PCSEL_CNT_W = 32;
	localparam logic [31:0] PCSEL_CNT_RESET = 32'h0000_0000;
	// avalon word offsets (byte addresses)
	localparam logic [3:0] PCSEL_OFS_CTRL  = 4'h0;
	localparam logic [3:0] PCSEL_OFS_COUNT = 4'h4;
	localparam logic [3:0] PCSEL_OFS_THR   = 4'h8;
	localparam logic [3:0] PCSEL_OFS_EVENT = 4'hc;
	// control field positions
	localparam int PCSEL_CTRL_SEL_LSB  = 0;
	localparam int PCSEL_CTRL_TBS_LSB  = 8;
	localparam int PCSEL_CTRL_MUL_LSB  = 16;
	localparam int PCSEL_CTRL_CE_BIT   = 24;
	localparam logic [31:0] PCSEL_CTRL_RESET = 32'h0000_0000;
	localparam logic [31:0] PCSEL_THR_RESET  = 32'h0000_0000;
	localparam logic [31:0] PCSEL_UNMAPPED   = 32'h0000_0000;
	localparam int PCSEL_TB_W = 32;
	typedef enum logic [1:0] {
		PCSEL_BUS_IDLE = 2'b00,
		PCSEL_BUS_ACK  = 2'b01
	} pcsel_bus_t;
endpackage

// >>> sim/pcsel_core_model.sv
// behavioural core pipeline driving the event sources of the counter
`timescale 1ns/1ps
module pcsel_core_model (
	// bench control
	input  wire logic        act,
	input  wire logic [1:0]  v,
	input  wire logic [4:0]  tbit,
	input  wire logic        zl,
	// event sources
	output logic      [1:0]  cnt2,
	output logic             pulse,
	output logic      [31:0] tb,
	output logic             zero_len
);
	// per-cycle counts; folded branches never reach completion here
	assign cnt2 = act ? v : 2'h0;
	assign pulse = act;
	// only the chosen bit toggles, so a wrong bit choice counts nothing
	assign tb = act ? (32'h0000_0001 << tbit) : 32'h0000_0000;
	assign zero_len = act & zl;
endmodule // pcsel_core_model

// >>> sim/tb_perf_counter3_event_select.sv
// self-checking bench for the third counter event selection
`timescale 1ns/1ps
module tb_perf_counter3_event_select;
	import pcsel_pkg::*;
	localparam int NP = 4;
	logic        clk = 1'b0;
	logic        rst_b = 1'b0;
	logic [3:0]  avs_address = 4'h0;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic        act = 1'b0;
	logic        zl = 1'b0;
	logic        tr = 1'b0;
	logic [1:0]  v = 2'h0;
	logic [4:0]  tbit = 5'h1f;
	logic [1:0]  cnt2;
	logic        pulse;
	logic        zero_len;
	logic [31:0] tb;
	logic [31:0] third_event_counter;
	int          fail_count = 0;
	int          check_count = 0;
	always #5 clk = ~clk;
	pcsel_core_model core (.act(act), .v(v), .tbit(tbit), .zl(zl),
		.cnt2(cnt2), .pulse(pulse), .tb(tb), .zero_len(zero_len));
	pcsel_counter dut (.clk(clk), .rst_b(rst_b), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(4'hf),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.timebase_lower(tb), .monitor_in(pulse), .completed_count(cnt2),
		.dispatched_count(cnt2), .vr_dispatch_count(cnt2),
		.vr_stall_count(cnt2), .int_rename_valid({4'h0, cnt2}),
		.fp_queue_valid({2'h0, cnt2}), .fpu_complete(pulse),
		.stwcx_complete(pulse), .load_piece_count(cnt2),
		.zero_len_load_string(zero_len), .single_step_trace(tr),
		.itable_search_active(pulse), .data_translation_buffer_miss(pulse),
		.icache_miss_cancel(pulse), .dcache_op_hit(pulse),
		.lmq_oldest_wait(pulse), .snoop_push(pulse), .dcache_miss(pulse),
		.stream2_fetch(pulse), .taken_branch_count(cnt2),
		.branch_flush(pulse), .buf2_correct(pulse), .buf3_active(pulse),
		.ctr_stall(pulse), .fast_branch_target_cache_hit(pulse), .link_stack_miss(pulse),
		.other_counter_negative(pulse),
		.other_counter_condition_enable(1'b1),
		.third_event_counter(third_event_counter));
	task automatic print_verdict;
		if (fail_count == 0 && check_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task automatic check32(string name, logic [31:0] e, logic [31:0] g);
		check_count++;
		if (g !== e) begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", name, e, g);
		end
	endtask
	// holds the request until waitrequest is seen low at a rising edge
	task automatic bus(logic wr, logic [3:0] a, logic [31:0] d,
		output logic [31:0] q);
		int i;
		@(posedge clk);
		avs_address <= a;
		avs_write <= wr;
		avs_read <= ~wr;
		avs_writedata <= d;
		i = 0;
		do begin
			@(posedge clk);
			i++;
		end while (avs_waitrequest !== 1'b0 && i < 50);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		if (i >= 50) begin
			fail_count++;
			print_verdict();
		end
	endtask
	function automatic int exp_cnt(int c, int x);
		case (c)
			0, 6: return 0;
			2, 4, 10, 13, 16, 25: return x * NP;
			8: return (x == 2) ? NP : 0;
			9: return (x == 1) ? NP : 0;
			11: return ((x > 2) ? 2 : x) * NP;
			12: return (x >= 2) ? NP : 0;
			default: return NP;
		endcase
	endfunction
	// events stay quiet while select and count are set up and read back
	task automatic run(int c, int s, int x, logic z, logic t, int e);
		logic [31:0] q;
		int          bits [4] = '{31, 23, 19, 15};
		tr <= t;
		zl <= z;
		v <= x[1:0];
		tbit <= bits[s][4:0];
		bus(1'b1, PCSEL_OFS_CTRL, 32'(c) | (32'(s) << PCSEL_CTRL_TBS_LSB)
			| (32'h1 << PCSEL_CTRL_CE_BIT), q);
		bus(1'b1, PCSEL_OFS_COUNT, 32'h0, q);
		repeat (NP) begin
			@(posedge clk);
			act <= 1'b1;
			@(posedge clk);
			act <= 1'b0;
		end
		bus(1'b1, PCSEL_OFS_CTRL, 32'h0, q);
		bus(1'b0, PCSEL_OFS_COUNT, 32'h0, q);
		check32("count", 32'(e), q);
	endtask
	task automatic regs_check;
		logic [31:0] q;
		bus(1'b0, PCSEL_OFS_CTRL, 32'h0, q);
		check32("ctrl reset", PCSEL_CTRL_RESET, q);
		bus(1'b0, PCSEL_OFS_COUNT, 32'h0, q);
		check32("count reset", PCSEL_CNT_RESET, q);
		bus(1'b0, PCSEL_OFS_THR, 32'h0, q);
		check32("thr reset", PCSEL_THR_RESET, q);
		bus(1'b1, 4'h2, 32'hffff_ffff, q);
		bus(1'b0, 4'h2, 32'h0, q);
		check32("unmapped", PCSEL_UNMAPPED, q);
		bus(1'b1, PCSEL_OFS_THR, 32'h2, q);
		bus(1'b0, PCSEL_OFS_THR, 32'h0, q);
		check32("thr", 32'h2, q);
		bus(1'b1, PCSEL_OFS_COUNT, 32'h1234_5678, q);
		repeat (5) @(posedge clk);
		bus(1'b0, PCSEL_OFS_COUNT, 32'h0, q);
		check32("count hold", 32'h1234_5678, q);
	endtask
	// threshold zero makes every one-cycle search count once
	task automatic search_check;
		logic [31:0] q;
		bus(1'b1, PCSEL_OFS_THR, 32'h0, q);
		run(17, 0, 0, 1'b0, 1'b0, NP);
	endtask
	task automatic cycles_check;
		logic [31:0] q;
		logic [31:0] a;
		bus(1'b1, PCSEL_OFS_CTRL, 32'h1, q);
		@(posedge clk);
		a = third_event_counter;
		repeat (10) @(posedge clk);
		check32("cycles", a + 32'ha, third_event_counter);
	endtask
	initial begin
		repeat (6) @(posedge clk);
		rst_b <= 1'b1;
		regs_check();
		for (int x = 0; x < 4; x++) begin
			for (int c = 0; c < 32; c++) begin
				if (c != 1 && c != 17) begin
					run(c, 0, x, 1'b0, 1'b0, exp_cnt(c, x));
				end
			end
		end
		for (int s = 1; s < 4; s++) begin
			run(3, s, 0, 1'b0, 1'b0, NP);
		end
		run(16, 0, 0, 1'b1, 1'b1, NP);
		run(16, 0, 0, 1'b1, 1'b0, 0);
		search_check();
		cycles_check();
		print_verdict();
	end
endmodule // tb_perf_counter3_event_select
